// ---- design/bbms_supervisor.sv ----
// bbms_supervisor: mode, reverse, pass-through and adapter limit supervision
// assumes synchronous pins, analog comparator flags and a decoded register port
`timescale 1ns/1ps
module bbms_supervisor
  import bbms_pkg::*;
#(
  parameter int UV_DLY = UV_DELAY_CYC,
  parameter int PT_HOLD = PT_HOLD_CYC,
  parameter int DEB0 = DEB0_CYC,
  parameter int DEB1 = DEB1_CYC,
  parameter int DEB2 = DEB2_CYC,
  parameter int DEB3 = DEB3_CYC,
  parameter int TL_STEP = TL_STEP_CYC
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // pins
  input wire logic reverse_enable_pin,
  input wire logic battery_absent,
  input wire logic adapter_present,
  input wire logic adapter_por,
  input wire logic battery_first,
  input wire logic [15:0] resistor_limit,
  // comparator flags
  input wire logic adp_gt_92,
  input wire logic adp_gt_114,
  input wire logic adp_lt_106,
  input wire logic adp_lt_85,
  input wire logic adp_gt_sys_480,
  input wire logic adp_lt_sys_240,
  input wire logic vbat_gt_4v5,
  input wire logic rev_uv,
  input wire logic rev_ov,
  input wire logic rev_at_set,
  input wire logic rev_below_set,
  input wire logic sense_below_ov,
  input wire logic pt_in_window,
  input wire logic adapter_ov,
  input wire logic ideal_diode,
  input wire logic dischg_gt_600,
  input wire logic sys_abs_ov,
  input wire logic adp_near_limit,
  // bridge and loop controls
  output logic [1:0] input_high_fet,
  output logic [1:0] input_low_fet,
  output logic [1:0] output_low_fet,
  output logic [1:0] output_high_fet,
  output logic output_switch_gate,
  output logic reverse_power_good,
  output logic ref_to_input,
  output logic adapter_loop_hold,
  output logic limit_secondary_sel,
  output logic [15:0] adapter_limit_active,
  output logic [15:0] reverse_vset,
  output logic [15:0] reverse_ilim
);
  // ----------------------------------------
  // flag synchroniser
  // ----------------------------------------
  logic [17:0] flag_raw, sync1_q, sync2_q;
  logic s_gt92, s_gt114, s_lt106, s_lt85, s_gt480, s_lt240, s_vbat, s_uv, s_ov;
  logic s_at_set, s_below_set, s_sense_ok, s_win, s_adp_ov, s_idm, s_dis, s_sys_ov, s_near;
  assign flag_raw = {adp_gt_92, adp_gt_114, adp_lt_106, adp_lt_85, adp_gt_sys_480, adp_lt_sys_240,
    vbat_gt_4v5, rev_uv, rev_ov, rev_at_set, rev_below_set, sense_below_ov, pt_in_window,
    adapter_ov, ideal_diode, dischg_gt_600, sys_abs_ov, adp_near_limit};
  assign {s_gt92, s_gt114, s_lt106, s_lt85, s_gt480, s_lt240, s_vbat, s_uv, s_ov,
    s_at_set, s_below_set, s_sense_ok, s_win, s_adp_ov, s_idm, s_dis, s_sys_ov, s_near} = sync2_q;

  always_ff @(posedge clk)
  begin
    sync1_q <= rst_n ? flag_raw : 18'h00000;
    sync2_q <= rst_n ? sync1_q : 18'h00000;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] ctl1_q, ctl1_d, ctl3_q, ctl3_d, ctl4_q, ctl4_d, ctl5_q, ctl5_d, ctl7_q, ctl7_d;
  logic [15:0] lim1_q, lim1_d, lim2_q, lim2_d, rvset_q, rvset_d, rilim_q, rilim_d, rdata_q, rdata_d;
  bbms_op_t op_q, op_d;
  bbms_mode_t mode_q, mode_d;
  bbms_tl_t tl_q, tl_d;

  always_comb
  begin
    ctl1_d = ctl1_q;
    ctl3_d = ctl3_q;
    ctl4_d = ctl4_q;
    ctl5_d = ctl5_q;
    ctl7_d = ctl7_q;
    lim1_d = lim1_q;
    lim2_d = lim2_q;
    rvset_d = rvset_q;
    rilim_d = rilim_q;
    if (reg_wr)
    begin
      case (reg_addr)
        OFF_CTRL1: ctl1_d = reg_wdata;
        OFF_CTRL3: ctl3_d = reg_wdata;
        OFF_CTRL4: ctl4_d = reg_wdata;
        OFF_CTRL5: ctl5_d = reg_wdata;
        OFF_CTRL7: ctl7_d = reg_wdata;
        OFF_LIM1: lim1_d = reg_wdata;
        OFF_LIM2: lim2_d = reg_wdata;
        OFF_RVSET: rvset_d = reg_wdata & RVSET_MASK;
        OFF_RILIM: rilim_d = reg_wdata;
        default: ;
      endcase
    end
    if (adapter_por)
    begin
      lim1_d = resistor_limit;
      if (!battery_first)
      begin
        lim2_d = LIM2_RST;
      end
    end
    case (reg_addr)
      OFF_CTRL1: rdata_d = ctl1_q;
      OFF_CTRL3: rdata_d = ctl3_q;
      OFF_CTRL4: rdata_d = ctl4_q;
      OFF_CTRL5: rdata_d = ctl5_q;
      OFF_CTRL7: rdata_d = ctl7_q;
      OFF_LIM1: rdata_d = lim1_q;
      OFF_LIM2: rdata_d = lim2_q;
      OFF_RVSET: rdata_d = rvset_q;
      OFF_RILIM: rdata_d = rilim_q;
      OFF_INFO2: rdata_d = (16'(battery_absent) << BATT_BIT) | (16'({op_q[2], mode_q}) << MODE_LSB);
      OFF_INFO3: rdata_d = 16'(op_q == OP_PT) << PT_STAT_BIT;
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl1_q <= CTRL_RST;
      ctl3_q <= CTRL_RST;
      ctl4_q <= CTRL_RST;
      ctl5_q <= CTRL_RST;
      ctl7_q <= CTRL_RST;
      lim1_q <= LIM1_RST;
      lim2_q <= LIM2_RST;
      rvset_q <= RVSET_RST;
      rilim_q <= RILIM_RST;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ctl1_q <= ctl1_d;
      ctl3_q <= ctl3_d;
      ctl4_q <= ctl4_d;
      ctl5_q <= ctl5_d;
      ctl7_q <= ctl7_d;
      lim1_q <= lim1_d;
      lim2_q <= lim2_d;
      rvset_q <= rvset_d;
      rilim_q <= rilim_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // supervisor state
  // ----------------------------------------
  logic rev_ok, fb, forced, pt_fault, pg_q, pg_d, blk_q, blk_d;
  logic [1:0] pt_sel;
  logic [CNT_W-1:0] cnt_q, cnt_d, cnt_inc, deb_cyc;

  assign rev_ok = ctl4_q[REV_CMD_BIT] & reverse_enable_pin & s_vbat & !battery_absent;
  assign fb = ctl1_q[FORCE_BUCK_BIT];
  assign pt_sel = ctl3_q[PT_LSB +: 2];
  assign forced = pt_sel[1];
  assign pt_fault = s_adp_ov | s_idm | s_dis | s_sys_ov;
  assign cnt_inc = (&cnt_q) ? cnt_q : cnt_q + CNT_W'(1);

  always_comb
  begin
    case ({ctl3_q[DEB_HI_BIT], ctl4_q[DEB_LO_BIT]})
      2'h0: deb_cyc = CNT_W'(DEB0);
      2'h1: deb_cyc = CNT_W'(DEB1);
      2'h2: deb_cyc = CNT_W'(DEB2);
      default: deb_cyc = CNT_W'(DEB3);
    endcase
  end

  always_comb
  begin
    op_d = op_q;
    cnt_d = cnt_inc;
    blk_d = blk_q & (pt_sel != 2'h0);
    case (op_q)
      OP_IDLE:
      begin
        cnt_d = '0;
        if (rev_ok)
          op_d = OP_REV_DEB;
        else if (adapter_present)
          op_d = OP_FWD;
      end
      OP_FWD:
      begin
        if (rev_ok || !adapter_present)
          op_d = OP_IDLE;
        else if (pt_sel != 2'h0 && !blk_q)
          op_d = OP_PT_RAMP;
      end
      OP_PT_RAMP, OP_PT:
      begin
        if (!adapter_present)
          op_d = OP_IDLE;
        else if (pt_sel == 2'h0)
          op_d = OP_FWD;
        else if (!forced && pt_fault)
        begin
          op_d = OP_FWD;
          blk_d = 1'b1;
        end
        else if (op_q == OP_PT_RAMP && s_win)
        begin
          op_d = OP_PT;
          cnt_d = '0;
        end
      end
      OP_REV_DEB:
      begin
        if (!rev_ok)
          op_d = OP_IDLE;
        else if (cnt_q >= deb_cyc && s_sense_ok)
          op_d = OP_REV_RUN;
      end
      OP_REV_RUN:
      begin
        cnt_d = '0;
        if (!rev_ok)
          op_d = OP_IDLE;
        else if (s_ov)
          op_d = OP_REV_OV;
        else if (s_uv)
          op_d = OP_REV_UV;
      end
      OP_REV_UV:
      begin
        if (!rev_ok)
          op_d = OP_IDLE;
        else if (s_ov)
          op_d = OP_REV_OV;
        else if (cnt_q >= CNT_W'(UV_DLY - 1))
        begin
          op_d = OP_REV_DEB;
          cnt_d = '0;
        end
        else if (!s_uv)
          op_d = OP_REV_RUN;
      end
      OP_REV_OV:
      begin
        if (!rev_ok)
          op_d = OP_IDLE;
        else if (s_below_set)
          op_d = OP_REV_RUN;
      end
      default: op_d = OP_IDLE;
    endcase
    pg_d = (op_d == OP_REV_RUN) && (pg_q || s_at_set);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      op_q <= OP_IDLE;
      cnt_q <= '0;
      pg_q <= 1'b0;
      blk_q <= 1'b0;
    end
    else
    begin
      op_q <= op_d;
      cnt_q <= cnt_d;
      pg_q <= pg_d;
      blk_q <= blk_d;
    end
  end

  // ----------------------------------------
  // conversion mode
  // ----------------------------------------
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      FM_IDLE: mode_d = s_gt114 ? FM_BUCK : (s_gt92 ? FM_BB : FM_BOOST);
      FM_BOOST: if (s_gt92) mode_d = FM_BB;
      FM_BB:
        if (s_gt114 || (fb && s_gt480))
          mode_d = FM_BUCK;
        else if (s_lt85)
          mode_d = FM_BOOST;
      FM_BUCK: if (fb ? s_lt240 : s_lt106) mode_d = FM_BB;
      default: mode_d = FM_IDLE;
    endcase
    // latched pass-through freezes the mode
    if (op_q == OP_IDLE)
      mode_d = FM_IDLE;
    else if (op_q == OP_PT)
      mode_d = mode_q;
  end

  always_ff @(posedge clk)
  begin
    mode_q <= rst_n ? mode_d : FM_IDLE;
  end

  // ----------------------------------------
  // two-level adapter limit
  // ----------------------------------------
  logic [CNT_W-1:0] tl_cnt_q, tl_cnt_d;

  function automatic logic [CNT_W-1:0] tl_dur(logic [1:0] f);
    return CNT_W'((int'(f) + 1) * TL_STEP);
  endfunction : tl_dur

  always_comb
  begin
    tl_d = tl_q;
    tl_cnt_d = tl_cnt_q + CNT_W'(1);
    case (tl_q)
      TL_OFF:
      begin
        tl_cnt_d = '0;
        if (s_near)
          tl_d = TL_T2;
      end
      TL_T2:
        if (tl_cnt_q >= tl_dur(ctl5_q[T2_LSB +: 2]) - CNT_W'(1))
        begin
          tl_d = TL_T1;
          tl_cnt_d = '0;
        end
      TL_T1:
        if (tl_cnt_q >= tl_dur(ctl5_q[T1_LSB +: 2]) - CNT_W'(1))
        begin
          tl_d = TL_T2;
          tl_cnt_d = '0;
        end
      default: tl_d = TL_OFF;
    endcase
    if (!ctl3_q[TL_EN_BIT])
    begin
      tl_d = TL_OFF;
      tl_cnt_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    tl_q <= rst_n ? tl_d : TL_OFF;
    tl_cnt_q <= rst_n ? tl_cnt_d : '0;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic [7:0] fet_q, fet_d;
  logic gate_q, gate_d, ref_q, ref_d, hold_q, hold_d;
  logic [15:0] lim_q, lim_d;

  function automatic logic [7:0] fet_pat(bbms_op_t op, bbms_mode_t m);
    logic [7:0] p;
    p = PAT_OFF;
    case (op)
      OP_FWD, OP_PT_RAMP:
        p = (m == FM_BUCK) ? PAT_BUCK : (m == FM_BOOST) ? PAT_BOOST : (m == FM_BB) ? PAT_BB : PAT_OFF;
      OP_REV_RUN, OP_REV_UV:
        p = (m == FM_BUCK) ? PAT_RBUCK : (m == FM_BOOST) ? PAT_RBOOST : (m == FM_BB) ? PAT_RBB : PAT_OFF;
      OP_PT: p = PAT_PASS;
      default: p = PAT_OFF;
    endcase
    return p;
  endfunction : fet_pat

  always_comb
  begin
    fet_d = fet_pat(op_d, mode_d);
    gate_d = (op_d == OP_REV_RUN || op_d == OP_REV_UV || op_d == OP_REV_OV) && ctl3_q[GATE_BIT];
    ref_d = (op_d == OP_PT_RAMP || op_d == OP_PT);
    hold_d = (op_d == OP_PT) && (op_q != OP_PT || cnt_q < CNT_W'(PT_HOLD - 1));
    lim_d = (tl_d == TL_T2) ? lim2_q : lim1_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fet_q <= PAT_OFF;
      gate_q <= 1'b0;
      ref_q <= 1'b0;
      hold_q <= 1'b0;
      lim_q <= LIM1_RST;
    end
    else
    begin
      fet_q <= fet_d;
      gate_q <= gate_d;
      ref_q <= ref_d;
      hold_q <= hold_d;
      lim_q <= lim_d;
    end
  end

  assign {input_high_fet, input_low_fet, output_low_fet, output_high_fet} = fet_q;
  assign output_switch_gate = gate_q;
  assign reverse_power_good = pg_q;
  assign ref_to_input = ref_q;
  assign adapter_loop_hold = hold_q;
  assign limit_secondary_sel = (tl_q == TL_T2);
  assign adapter_limit_active = lim_q;
  assign reverse_vset = rvset_q;
  assign reverse_ilim = rilim_q;
  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_buck_pat;
    op_q == OP_FWD && mode_q == FM_BUCK |-> fet_q == PAT_BUCK;
  endproperty
  a_buck_pat: assert property (p_buck_pat) else $error("buck pattern wrong");
  property p_pass_pat;
    op_q == OP_PT |-> fet_q == PAT_PASS && ref_to_input;
  endproperty
  a_pass_pat: assert property (p_pass_pat) else $error("pass pattern wrong");
  property p_rise;
    op_q == OP_FWD && mode_q == FM_BOOST && s_gt92 |=> mode_q == FM_BB;
  endproperty
  a_rise: assert property (p_rise) else $error("boost did not leave");
  property p_fall;
    op_q == OP_FWD && mode_q == FM_BUCK && !fb && s_lt106 |=> mode_q == FM_BB;
  endproperty
  a_fall: assert property (p_fall) else $error("buck did not leave");
  property p_fbuck;
    op_q == OP_FWD && mode_q == FM_BB && fb && s_gt480 |=> mode_q == FM_BUCK;
  endproperty
  a_fbuck: assert property (p_fbuck) else $error("force buck missed");
  property p_rev_entry;
    $rose(op_q == OP_REV_DEB) && $past(op_q == OP_IDLE) |-> $past(rev_ok);
  endproperty
  a_rev_entry: assert property (p_rev_entry) else $error("reverse without enable");
  sequence s_start;
    op_q == OP_REV_DEB ##1 op_q == OP_REV_RUN;
  endsequence
  property p_start;
    s_start |-> $past(s_sense_ok) && $past(cnt_q >= deb_cyc);
  endproperty
  a_start: assert property (p_start) else $error("early reverse start");
  sequence s_uv_hit;
    op_q == OP_REV_RUN && rev_ok && s_uv && !s_ov;
  endsequence
  property p_uv;
    s_uv_hit |=> !reverse_power_good ##0 op_q == OP_REV_UV;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not handled");
  property p_ov;
    op_q == OP_REV_OV |-> fet_q == PAT_OFF && !reverse_power_good;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage still switching");
  property p_hold;
    $rose(op_q == OP_PT) |-> adapter_loop_hold [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("limit loop not held");
  property p_tl;
    tl_q == TL_OFF && ctl3_q[TL_EN_BIT] && s_near |=> limit_secondary_sel ##1 adapter_limit_active == lim2_q;
  endproperty
  a_tl: assert property (p_tl) else $error("two-level start missed");
  property p_info3;
    reg_addr == OFF_INFO3 |=> reg_rdata[PT_STAT_BIT] == $past(op_q == OP_PT);
  endproperty
  a_info3: assert property (p_info3) else $error("pass status wrong");
endmodule : bbms_supervisor

// ---- design/bbms_pkg.sv ----
// bbms_pkg: constants, register map and types of the buck-boost mode supervisor
// assumes a 40 MHz device clock and a decoded word-wide register port
package bbms_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int UV_DELAY_US = 32_000;
  localparam int UV_DELAY_CYC = UV_DELAY_US * CYC_PER_US;
  localparam int PT_HOLD_US = 1_000;
  localparam int PT_HOLD_CYC = PT_HOLD_US * CYC_PER_US + 1;
  localparam int DEB0_US = 1_000;
  localparam int DEB1_US = 5_000;
  localparam int DEB2_US = 10_000;
  localparam int DEB3_US = 20_000;
  localparam int DEB0_CYC = DEB0_US * CYC_PER_US;
  localparam int DEB1_CYC = DEB1_US * CYC_PER_US;
  localparam int DEB2_CYC = DEB2_US * CYC_PER_US;
  localparam int DEB3_CYC = DEB3_US * CYC_PER_US;
  localparam int TL_STEP_US = 1_000;
  localparam int TL_STEP_CYC = TL_STEP_US * CYC_PER_US;
  localparam int CNT_W = 21;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL1 = 8'h39;
  localparam logic [7:0] OFF_CTRL3 = 8'h3D;
  localparam logic [7:0] OFF_CTRL4 = 8'h4C;
  localparam logic [7:0] OFF_CTRL5 = 8'h4E;
  localparam logic [7:0] OFF_CTRL7 = 8'h36;
  localparam logic [7:0] OFF_LIM2 = 8'h3B;
  localparam logic [7:0] OFF_LIM1 = 8'h3F;
  localparam logic [7:0] OFF_RVSET = 8'h49;
  localparam logic [7:0] OFF_RILIM = 8'h4A;
  localparam logic [7:0] OFF_INFO2 = 8'h4D;
  localparam logic [7:0] OFF_INFO3 = 8'h90;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int FORCE_BUCK_BIT = 1;
  localparam int PT_LSB = 0;
  localparam int GATE_BIT = 5;
  localparam int TL_EN_BIT = 12;
  localparam int DEB_HI_BIT = 13;
  localparam int DEB_LO_BIT = 0;
  localparam int REV_CMD_BIT = 2;
  localparam int T2_LSB = 0;
  localparam int T1_LSB = 2;
  localparam int MODE_LSB = 5;
  localparam int BATT_BIT = 12;
  localparam int PT_STAT_BIT = 1;
  localparam logic [15:0] RVSET_MASK = 16'h7FF8;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] RVSET_RST = 16'h0D08;
  localparam logic [15:0] RILIM_RST = 16'h0200;
  localparam logic [15:0] LIM1_RST = 16'h0100;
  localparam logic [15:0] LIM2_RST = 16'h00BC;
  // ----------------------------------------
  // types and switch patterns {in_hi, in_lo, out_lo, out_hi}
  // ----------------------------------------
  typedef enum logic [1:0] {R_OFF = 2'h0, R_ON = 2'h1, R_CTRL = 2'h2, R_SYNC = 2'h3} bbms_role_t;
  typedef enum logic [1:0] {FM_IDLE = 2'h0, FM_BOOST = 2'h1, FM_BB = 2'h3, FM_BUCK = 2'h2} bbms_mode_t;
  typedef enum logic [2:0] {
    OP_IDLE = 3'h0, OP_FWD = 3'h1, OP_PT_RAMP = 3'h3, OP_PT = 3'h2,
    OP_REV_DEB = 3'h6, OP_REV_RUN = 3'h7, OP_REV_UV = 3'h5, OP_REV_OV = 3'h4
  } bbms_op_t;
  typedef enum logic [1:0] {TL_OFF = 2'h0, TL_T2 = 2'h1, TL_T1 = 2'h3} bbms_tl_t;
  localparam logic [7:0] PAT_OFF = {R_OFF, R_OFF, R_OFF, R_OFF};
  localparam logic [7:0] PAT_BUCK = {R_CTRL, R_SYNC, R_OFF, R_ON};
  localparam logic [7:0] PAT_BOOST = {R_ON, R_OFF, R_CTRL, R_SYNC};
  localparam logic [7:0] PAT_BB = {R_CTRL, R_SYNC, R_CTRL, R_SYNC};
  localparam logic [7:0] PAT_RBUCK = {R_ON, R_OFF, R_SYNC, R_CTRL};
  localparam logic [7:0] PAT_RBOOST = {R_SYNC, R_CTRL, R_OFF, R_ON};
  localparam logic [7:0] PAT_RBB = {R_SYNC, R_CTRL, R_SYNC, R_CTRL};
  localparam logic [7:0] PAT_PASS = {R_ON, R_OFF, R_OFF, R_ON};
endpackage : bbms_pkg

// ---- sim/bbms_bridge_model.sv ----
// bbms_bridge_model: reverse output stage behind the bridge
// assumes fet roles as coded in bbms_pkg
`timescale 1ns/1ps
module bbms_bridge_model
  import bbms_pkg::*;
(
  // bridge side
  input wire logic clk,
  input wire logic output_switch_gate,
  input wire logic [1:0] output_high_fet,
  // output sense
  output logic rev_at_set,
  output logic rev_below_set
);
  logic [2:0] ramp_q = 3'h0;
  // output only rises while switching into a closed gate
  always @(posedge clk)
    ramp_q <= (output_switch_gate && output_high_fet != 2'h0) ? ramp_q + 3'(ramp_q != 3'h7) : 3'h0;
  assign rev_at_set = ramp_q == 3'h7;
  assign rev_below_set = !rev_at_set;
endmodule : bbms_bridge_model

// ---- sim/bbms_supervisor_bench.sv ----
// bbms_supervisor_bench: register and pin sequences for the supervisor
// assumes shortened delay parameters and the bridge model
`timescale 1ns/1ps
module bbms_supervisor_bench
  import bbms_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reverse_enable_pin = 1'b0, battery_absent = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, adapter_limit_active, reverse_vset, reverse_ilim;
  logic [15:0] resistor_limit = 16'h0155;
  logic adapter_present = 1'b0, adapter_por = 1'b0, battery_first = 1'b0, vbat_gt_4v5 = 1'b0;
  logic rev_uv = 1'b0, rev_ov = 1'b0, sense_below_ov = 1'b0, adp_gt_92 = 1'b0, adp_gt_114 = 1'b0;
  logic adp_lt_106 = 1'b0, adp_lt_85 = 1'b0, pt_in_window = 1'b0, adp_gt_sys_480 = 1'b0;
  logic adp_lt_sys_240 = 1'b0, adp_near_limit = 1'b0, rev_at_set, rev_below_set;
  logic [3:0] pt_exit = 4'h0;
  logic [1:0] input_high_fet, input_low_fet, output_low_fet, output_high_fet;
  logic output_switch_gate, reverse_power_good, limit_secondary_sel, ref_to_input, adapter_loop_hold;
  int bad_count = 0, num_checks = 0, cyc = 0, n;
  wire [15:0] pat = {8'h00, input_high_fet, input_low_fet, output_low_fet, output_high_fet};

  always #12.5 clk = ~clk;

  bbms_supervisor #(.UV_DLY(20), .PT_HOLD(10), .DEB0(5), .DEB1(6), .DEB2(7), .DEB3(8), .TL_STEP(4))
  bbms_supervisor_inst (
    .clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .reverse_enable_pin, .battery_absent,
    .adapter_present, .adapter_por, .battery_first, .resistor_limit, .adp_gt_92, .adp_gt_114,
    .adp_lt_106, .adp_lt_85, .adp_gt_sys_480, .adp_lt_sys_240, .vbat_gt_4v5, .rev_uv, .rev_ov,
    .rev_at_set, .rev_below_set, .sense_below_ov, .pt_in_window, .adapter_ov(pt_exit[0]),
    .ideal_diode(pt_exit[1]), .dischg_gt_600(pt_exit[2]), .sys_abs_ov(pt_exit[3]), .adp_near_limit,
    .input_high_fet, .input_low_fet, .output_low_fet, .output_high_fet, .output_switch_gate,
    .reverse_power_good, .ref_to_input, .adapter_loop_hold, .limit_secondary_sel,
    .adapter_limit_active, .reverse_vset, .reverse_ilim
  );

  bbms_bridge_model bbms_bridge_model_inst (
    .clk, .output_switch_gate, .output_high_fet, .rev_at_set, .rev_below_set
  );

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // values are read at the edge, so they are the settled pre-edge ones
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    // two edges of flag sync, one of state, one of read data
    tick(4);
    chk(reg_rdata & m, exp);
  endtask : rd

  task automatic wait_sel(input logic lvl);
    for (n = 0; n < 20 && limit_secondary_sel !== lvl; n++)
      @(posedge clk);
  endtask : wait_sel

  // hang guard, run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  initial
  begin
    tick(12);
    rst_n <= 1'b1;
    chk(pat, {8'h00, PAT_OFF});
    rd(OFF_RVSET, 16'hFFFF, RVSET_RST);
    chk(reverse_vset, RVSET_RST);
    rd(OFF_RILIM, 16'hFFFF, RILIM_RST);
    chk(reverse_ilim, RILIM_RST);
    wr(OFF_RVSET, 16'hFFFF);
    rd(OFF_RVSET, 16'hFFFF, RVSET_MASK);
    chk(reverse_vset, RVSET_MASK);
    wr(OFF_LIM2, 16'h1234);
    // battery first keeps the written secondary
    battery_first <= 1'b1;
    adapter_por <= 1'b1;
    tick(1);
    adapter_por <= 1'b0;
    rd(OFF_LIM2, 16'hFFFF, 16'h1234);
    battery_first <= 1'b0;
    adapter_por <= 1'b1;
    tick(1);
    adapter_por <= 1'b0;
    rd(OFF_LIM1, 16'hFFFF, 16'h0155);
    rd(OFF_LIM2, 16'hFFFF, LIM2_RST);
    adapter_present <= 1'b1;
    adp_gt_92 <= 1'b1;
    adp_gt_114 <= 1'b1;
    tick(12);
    chk(pat, {8'h00, PAT_BUCK});
    rd(OFF_INFO2, 16'h00E0, 16'h0040);
    adp_gt_114 <= 1'b0;
    adp_lt_106 <= 1'b1;
    rd(OFF_INFO2, 16'h00E0, 16'h0060);
    adp_gt_92 <= 1'b0;
    adp_lt_85 <= 1'b1;
    rd(OFF_INFO2, 16'h00E0, 16'h0020);
    chk(pat, {8'h00, PAT_BOOST});
    adp_gt_92 <= 1'b1;
    adp_lt_85 <= 1'b0;
    tick(6);
    chk(pat, {8'h00, PAT_BB});
    wr(OFF_CTRL1, 16'h0002);
    adp_gt_sys_480 <= 1'b1;
    rd(OFF_INFO2, 16'h00E0, 16'h0040);
    adp_gt_sys_480 <= 1'b0;
    adp_lt_sys_240 <= 1'b1;
    rd(OFF_INFO2, 16'h00E0, 16'h0060);
    wr(OFF_CTRL1, 16'h0000);
    adp_gt_114 <= 1'b1;
    adp_lt_106 <= 1'b0;
    pt_in_window <= 1'b1;
    wr(OFF_CTRL7, 16'h0040);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_CTRL3, 16'h0000);
      wr(OFF_CTRL3, 16'h0001);
      tick(6);
      chk(pat, {8'h00, PAT_PASS});
      rd(OFF_INFO3, 16'h0002, 16'h0002);
      chk(16'({ref_to_input, adapter_loop_hold}), 16'h0003);
      pt_exit <= 4'h1 << i;
      rd(OFF_INFO3, 16'h0002, 16'h0000);
      chk(16'({ref_to_input, adapter_loop_hold}), 16'h0000);
      pt_exit <= 4'h0;
    end
    wr(OFF_CTRL3, 16'h0000);
    wr(OFF_CTRL3, 16'h0003);
    pt_exit <= 4'hF;
    rd(OFF_INFO3, 16'h0002, 16'h0002);
    // stay latched past the hold window
    tick(8);
    chk(16'({ref_to_input, adapter_loop_hold}), 16'h0002);
    wr(OFF_CTRL3, 16'h0000);
    rd(OFF_INFO3, 16'h0002, 16'h0000);
    chk(16'(ref_to_input), 16'h0000);
    pt_exit <= 4'h0;
    wr(OFF_CTRL5, 16'h0000);
    wr(OFF_CTRL3, 16'h1000);
    adp_near_limit <= 1'b1;
    wait_sel(1'b1);
    tick(1);
    chk(adapter_limit_active, LIM2_RST);
    wait_sel(1'b0);
    tick(1);
    chk(adapter_limit_active, 16'h0155);
    // disabled: the secondary never comes back
    wr(OFF_CTRL3, 16'h0000);
    tick(2);
    wait_sel(1'b1);
    chk(16'(n), 16'h0014);
    chk(adapter_limit_active, 16'h0155);
    adp_near_limit <= 1'b0;
    adapter_present <= 1'b0;
    vbat_gt_4v5 <= 1'b1;
    sense_below_ov <= 1'b1;
    reverse_enable_pin <= 1'b1;
    wr(OFF_CTRL3, 16'h0020);
    wr(OFF_CTRL4, 16'h0004);
    tick(15);
    chk(16'(output_switch_gate), 16'h0001);
    chk(pat, {8'h00, PAT_RBUCK});
    rd(OFF_INFO2, 16'h00E0, 16'h00C0);
    tick(12);
    chk(16'(reverse_power_good), 16'h0001);
    rev_ov <= 1'b1;
    tick(4);
    chk(pat, {8'h00, PAT_OFF});
    chk(16'(reverse_power_good), 16'h0000);
    rev_ov <= 1'b0;
    tick(16);
    chk(16'(reverse_power_good), 16'h0001);
    rev_uv <= 1'b1;
    tick(5);
    chk(16'(reverse_power_good), 16'h0000);
    for (n = 0; n < 40 && output_switch_gate !== 1'b0; n++)
      @(posedge clk);
    chk(16'(n > 14 && n < 26), 16'h0001);
    battery_absent <= 1'b1;
    rd(OFF_INFO2, 16'h10E0, 16'h1000);
    chk(16'(output_switch_gate), 16'h0000);
    print_verdict();
  end
endmodule : bbms_supervisor_bench
